// File: tm16_timer.sv
// 16-bit timer with waveform mode control, compare and capture
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "tm16_params.svh"
module tm16_timer (
  // Clock, reset, clock enable
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Register port
  input wire tm16_pkg::tm_bus_req_s bus_i,
  output logic [7:0] rdata_o,
  // Timer tick from the prescaler, same clock
  input wire logic timer_tick_i,
  // Pins and port logic
  input wire logic capture_in_pin_i,
  input wire logic dir_a_i,
  input wire logic dir_b_i,
  input wire logic port_a_i,
  input wire logic port_b_i,
  output logic wave_out_a_o,
  output logic wave_out_a_oe_o,
  output logic wave_out_b_o,
  output logic wave_out_b_oe_o,
  output logic capture_pin_enabled_o
);
  import tm16_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] out_ctl_reg;
  logic [7:0] clk_ctl_reg;
  logic [7:0] temp_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] flags_reg;
  logic [3:0] flag_set;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] capture_reg;
  logic [15:0] cmp_buf_reg [2];
  logic [15:0] cmp_work_reg [2];
  tm_dir_e dir_reg;
  tm_dir_e dir_next;
  logic block_reg;
  logic cap_meta_reg;
  logic cap_sync_reg;
  logic cap_prev_reg;

  logic [3:0] wave_mode;
  tm_cls_e cls;
  logic buffered;
  logic cap_top;
  logic [15:0] top_value;
  logic at_top;
  logic at_bot;
  logic ovf_evt;
  logic load_evt;
  logic wrap_evt;
  logic cap_evt;
  logic wr_cnt;
  logic wr_cap;
  logic [1:0] wr_cmp;
  logic [15:0] wide_wdata;
  logic [1:0] match_raw;
  logic [1:0] match_wave;
  logic [1:0] pin_val;
  logic [1:0] pin_oe;
  logic [1:0] dir_pins;
  logic [1:0] port_vals;
  tm_chan_ctl_s chan_ctl [2];

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign wave_mode = {clk_ctl_reg[`TM_WM_HIGH_RANGE],
    out_ctl_reg[`TM_WM_LOW_RANGE]};
  assign cls = tm_class(wave_mode);
  // Immediate update in Normal, clear-on-match and reserved codes
  assign buffered = (cls != TM_CLS_NORMAL);
  assign cap_top = tm_cap_top(wave_mode);

  always_comb begin
    unique case (wave_mode)
      4'h1, 4'h5: top_value = `TM_TOP_8;
      4'h2, 4'h6: top_value = `TM_TOP_9;
      4'h3, 4'h7: top_value = `TM_TOP_10;
      `TM_WM_CTC_A, `TM_WM_PFC_A, `TM_WM_PC_A, `TM_WM_FAST_A:
        top_value = cmp_work_reg[0];
      `TM_WM_PFC_CAP, `TM_WM_PC_CAP, `TM_WM_CTC_CAP, `TM_WM_FAST_CAP:
        top_value = capture_reg;
      default: top_value = `TM_TOP_MAX;
    endcase
  end

  assign at_top = (count_reg == top_value);
  assign at_bot = (count_reg == `TM_BOTTOM);
  assign wrap_evt = timer_tick_i && at_top && (cls == TM_CLS_FAST);

  // Both references use the tick on which the counter holds the value
  always_comb begin
    ovf_evt = 1'b0;
    load_evt = 1'b0;
    unique case (cls)
      TM_CLS_NORMAL: begin
        ovf_evt = timer_tick_i && (count_reg == `TM_TOP_MAX);
      end
      TM_CLS_FAST: begin
        ovf_evt = wrap_evt;
        load_evt = wrap_evt;
      end
      TM_CLS_DUAL: begin
        ovf_evt = timer_tick_i && at_bot && (dir_reg == TM_DIR_DOWN);
        if ((wave_mode == `TM_WM_PFC_CAP) || (wave_mode == `TM_WM_PFC_A))
          load_evt = ovf_evt;
        else
          load_evt = timer_tick_i && at_top &&
            (dir_reg == TM_DIR_UP);
      end
    endcase
  end

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  assign wide_wdata = {temp_reg, bus_i.wdata};
  assign wr_cnt = bus_i.wr && (bus_i.addr == `TM_OFS_CNT_LO);
  assign wr_cap = bus_i.wr && (bus_i.addr == `TM_OFS_CAP_LO);
  assign wr_cmp[0] = bus_i.wr && (bus_i.addr == `TM_OFS_CMPA_LO);
  assign wr_cmp[1] = bus_i.wr && (bus_i.addr == `TM_OFS_CMPB_LO);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      out_ctl_reg <= `TM_CTL_RESET;
      clk_ctl_reg <= `TM_CTL_RESET;
    end else if (ce_i && bus_i.wr) begin
      if (bus_i.addr == `TM_OFS_OUT_CTL)
        out_ctl_reg <= bus_i.wdata & `TM_OUT_CTL_WMASK;
      if (bus_i.addr == `TM_OFS_CLK_CTL)
        clk_ctl_reg <= bus_i.wdata & `TM_CLK_CTL_WMASK;
    end
  end

  // Shared high byte keeps 16-bit accesses atomic
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      temp_reg <= 8'h00;
    end else if (ce_i) begin
      if (bus_i.wr && bus_i.addr[0] && bus_i.addr >= `TM_OFS_CNT_LO &&
          bus_i.addr <= `TM_OFS_CMPB_HI)
        temp_reg <= bus_i.wdata;
      else if (bus_i.rd) begin
        unique case (bus_i.addr)
          `TM_OFS_CNT_LO: temp_reg <= count_reg[15:8];
          `TM_OFS_CAP_LO: temp_reg <= capture_reg[15:8];
          `TM_OFS_CMPA_LO: temp_reg <= cmp_buf_reg[0][15:8];
          `TM_OFS_CMPB_LO: temp_reg <= cmp_buf_reg[1][15:8];
          default: temp_reg <= temp_reg;
        endcase
      end
    end
  end

  always_comb begin
    unique case (bus_i.addr)
      `TM_OFS_OUT_CTL: rdata_next = out_ctl_reg;
      `TM_OFS_CLK_CTL: rdata_next = clk_ctl_reg;
      `TM_OFS_CNT_LO: rdata_next = count_reg[7:0];
      `TM_OFS_CAP_LO: rdata_next = capture_reg[7:0];
      `TM_OFS_CMPA_LO: rdata_next = cmp_buf_reg[0][7:0];
      `TM_OFS_CMPB_LO: rdata_next = cmp_buf_reg[1][7:0];
      `TM_OFS_CNT_HI, `TM_OFS_CAP_HI, `TM_OFS_CMPA_HI, `TM_OFS_CMPB_HI:
        rdata_next = temp_reg;
      `TM_OFS_FLAGS: rdata_next = {4'h0, flags_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_reg <= 8'h00;
    end else if (ce_i) begin
      rdata_reg <= bus_i.rd ? rdata_next : 8'h00;
    end
  end

  assign rdata_o = rdata_reg;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_comb begin
    count_next = count_reg;
    dir_next = dir_reg;
    if (timer_tick_i) begin
      if (cls != TM_CLS_DUAL) begin
        count_next = at_top ? `TM_BOTTOM : count_reg + 16'h0001;
      end else if (dir_reg == TM_DIR_UP) begin
        if (at_top) begin
          dir_next = TM_DIR_DOWN;
          count_next = count_reg - 16'h0001;
        end else begin
          count_next = count_reg + 16'h0001;
        end
      end else if (at_bot) begin
        dir_next = TM_DIR_UP;
        count_next = count_reg + 16'h0001;
      end else begin
        count_next = count_reg - 16'h0001;
      end
    end
    if (wr_cnt)
      count_next = wide_wdata;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_reg <= `TM_BOTTOM;
      dir_reg <= TM_DIR_UP;
    end else if (ce_i) begin
      count_reg <= count_next;
      dir_reg <= (cls == TM_CLS_DUAL) ? dir_next : TM_DIR_UP;
    end
  end

  // A counter write masks the compare on the next tick
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      block_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_cnt)
        block_reg <= 1'b1;
      else if (timer_tick_i)
        block_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Compare channels
  // ----------------------------------------
  assign dir_pins = {dir_b_i, dir_a_i};
  assign port_vals = {port_b_i, port_a_i};

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        cmp_buf_reg[ch] <= `TM_BOTTOM;
        cmp_work_reg[ch] <= `TM_BOTTOM;
      end else if (ce_i) begin
        if (wr_cmp[ch])
          cmp_buf_reg[ch] <= wide_wdata;
        if (wr_cmp[ch] && !buffered)
          cmp_work_reg[ch] <= wide_wdata;
        else if (load_evt && buffered)
          cmp_work_reg[ch] <= cmp_buf_reg[ch];
      end
    end

    assign match_raw[ch] = timer_tick_i && !block_reg &&
      (count_reg == cmp_work_reg[ch]);
    assign chan_ctl[ch].cls = cls;
    assign chan_ctl[ch].action = (ch == 0) ?
      out_ctl_reg[`TM_ACT_A_RANGE] : out_ctl_reg[`TM_ACT_B_RANGE];
    assign chan_ctl[ch].toggle_ok = (cls == TM_CLS_NORMAL) ||
      ((ch == 0) && tm_toggle_ok(wave_mode));
    assign match_wave[ch] = match_raw[ch] && !((cls == TM_CLS_FAST) &&
      (cmp_work_reg[ch] == top_value) && chan_ctl[ch].action[1]);

    tm16_wave_unit u_wave (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .ctl_i(chan_ctl[ch]),
      .match_i(match_wave[ch]),
      .wrap_i(wrap_evt),
      .count_up_i(dir_reg == TM_DIR_UP),
      .dir_out_i(dir_pins[ch]),
      .port_val_i(port_vals[ch]),
      .pin_o(pin_val[ch]),
      .pin_oe_o(pin_oe[ch])
    );
  end

  assign wave_out_a_o = pin_val[0];
  assign wave_out_a_oe_o = pin_oe[0];
  assign wave_out_b_o = pin_val[1];
  assign wave_out_b_oe_o = pin_oe[1];

  // ----------------------------------------
  // Capture input
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cap_meta_reg <= 1'b0;
      cap_sync_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else if (ce_i) begin
      cap_meta_reg <= capture_in_pin_i;
      cap_sync_reg <= cap_meta_reg;
      cap_prev_reg <= cap_sync_reg;
    end
  end

  assign cap_evt = !cap_top && (clk_ctl_reg[`TM_EDGE_SEL_BIT] ?
    (cap_sync_reg && !cap_prev_reg) :
    (!cap_sync_reg && cap_prev_reg));
  assign capture_pin_enabled_o = !cap_top;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      capture_reg <= `TM_BOTTOM;
    end else if (ce_i) begin
      if (wr_cap)
        capture_reg <= wide_wdata;
      else if (cap_evt)
        capture_reg <= count_reg;
    end
  end

  // ----------------------------------------
  // Flags, write one to clear, set wins
  // ----------------------------------------
  always_comb begin
    flag_set = 4'h0;
    flag_set[`TM_FLAG_OVF] = ovf_evt;
    flag_set[`TM_FLAG_MA] = match_raw[0];
    flag_set[`TM_FLAG_MB] = match_raw[1];
    flag_set[`TM_FLAG_CAP] = cap_evt;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      flags_reg <= 4'h0;
    end else if (ce_i) begin
      if (bus_i.wr && bus_i.addr == `TM_OFS_FLAGS)
        flags_reg <= (flags_reg & ~bus_i.wdata[3:0]) | flag_set;
      else
        flags_reg <= flags_reg | flag_set;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i || !ce_i);

  sequence wr_low_s;
    bus_i.wr && bus_i.addr == `TM_OFS_OUT_CTL;
  endsequence
  sequence wr_high_s;
    bus_i.wr && bus_i.addr == `TM_OFS_CLK_CTL;
  endsequence

  ctl_a_mask_a: assert property (
    wr_low_s |=> out_ctl_reg == ($past(bus_i.wdata) & `TM_OUT_CTL_WMASK))
    else $error("control A write not masked");
  rsvd_read_a: assert property (
    bus_i.rd && bus_i.addr == `TM_OFS_OUT_CTL |=> rdata_o[3:2] == 2'b00)
    else $error("reserved bits read nonzero");
  mode_build_a: assert property (
    wr_low_s ##1 wr_high_s |=> wave_mode ==
      {$past(bus_i.wdata[4:3]), $past(bus_i.wdata[1:0], 2)})
    else $error("wave mode not built from both registers");
  cmp_immediate_a: assert property (
    wr_cmp[0] && !buffered |=> cmp_work_reg[0] == $past(wide_wdata))
    else $error("non-buffered compare not immediate");
  cmp_hold_a: assert property (
    buffered && !load_evt |=> cmp_work_reg[1] == $past(cmp_work_reg[1]))
    else $error("buffered compare changed outside load");
  count_hold_a: assert property (
    !timer_tick_i && !wr_cnt |=> $stable(count_reg))
    else $error("counter moved without tick");
  ovf_fast_a: assert property (
    wrap_evt && !wr_cnt |=> flags_reg[`TM_FLAG_OVF] &&
      count_reg == `TM_BOTTOM)
    else $error("fast PWM overflow not at TOP");
  ovf_dual_a: assert property (
    cls == TM_CLS_DUAL && timer_tick_i && at_bot && dir_reg == TM_DIR_DOWN
    && !wr_cnt |=> flags_reg[`TM_FLAG_OVF] && dir_reg == TM_DIR_UP)
    else $error("dual-slope overflow not at BOTTOM");
  ctc_wrap_a: assert property (
    wave_mode == `TM_WM_CTC_A && timer_tick_i && at_top && !wr_cnt
    |=> count_reg == `TM_BOTTOM)
    else $error("clear-on-match did not clear");
  cap_off_a: assert property (
    cap_top && !wr_cap |=> $stable(capture_reg))
    else $error("capture active while it defines TOP");
endmodule : tm16_timer

// File: tm16_params.svh
// Constants for the 16-bit timer waveform mode and output control block
`ifndef TM16_PARAMS_SVH
`define TM16_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TM_OFS_OUT_CTL 8'h80
`define TM_OFS_CLK_CTL 8'h81
`define TM_OFS_CNT_LO 8'h84
`define TM_OFS_CNT_HI 8'h85
`define TM_OFS_CAP_LO 8'h86
`define TM_OFS_CAP_HI 8'h87
`define TM_OFS_CMPA_LO 8'h88
`define TM_OFS_CMPA_HI 8'h89
`define TM_OFS_CMPB_LO 8'h8a
`define TM_OFS_CMPB_HI 8'h8b
`define TM_OFS_FLAGS 8'h90
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TM_OUT_CTL_WMASK 8'hf3
`define TM_CLK_CTL_WMASK 8'hdf
`define TM_CTL_RESET 8'h00
`define TM_ACT_A_RANGE 7:6
`define TM_ACT_B_RANGE 5:4
`define TM_RSVD_RANGE 3:2
`define TM_WM_LOW_RANGE 1:0
`define TM_WM_HIGH_RANGE 4:3
`define TM_EDGE_SEL_BIT 6
`define TM_FLAG_OVF 0
`define TM_FLAG_MA 1
`define TM_FLAG_MB 2
`define TM_FLAG_CAP 3
`define TM_ACT_TOGGLE 2'h1
// ----------------------------------------
// Fixed TOP values and modes
// ----------------------------------------
`define TM_BOTTOM 16'h0000
`define TM_TOP_MAX 16'hffff
`define TM_TOP_8 16'h00ff
`define TM_TOP_9 16'h01ff
`define TM_TOP_10 16'h03ff
`define TM_WM_CTC_A 4'h4
`define TM_WM_PFC_CAP 4'h8
`define TM_WM_PFC_A 4'h9
`define TM_WM_PC_CAP 4'ha
`define TM_WM_PC_A 4'hb
`define TM_WM_CTC_CAP 4'hc
`define TM_WM_FAST_CAP 4'he
`define TM_WM_FAST_A 4'hf
`endif

// File: tm16_pkg.sv
// Types and mode decoders for the 16-bit timer block
package tm16_pkg;
  `include "tm16_params.svh"

  typedef enum logic [2:0] {
    TM_CLS_NORMAL = 3'b001,
    TM_CLS_FAST = 3'b010,
    TM_CLS_DUAL = 3'b100
  } tm_cls_e;

  typedef enum logic [1:0] {
    TM_DIR_UP = 2'b01,
    TM_DIR_DOWN = 2'b10
  } tm_dir_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tm_bus_req_s;

  typedef struct packed {
    tm_cls_e cls;
    logic [1:0] action;
    logic toggle_ok;
  } tm_chan_ctl_s;

  // Reserved code 13 falls into the normal class
  function automatic tm_cls_e tm_class(input logic [3:0] m);
    unique case (m)
      4'h1, 4'h2, 4'h3, `TM_WM_PFC_CAP, `TM_WM_PFC_A, `TM_WM_PC_CAP,
      `TM_WM_PC_A: tm_class = TM_CLS_DUAL;
      4'h5, 4'h6, 4'h7, `TM_WM_FAST_CAP, `TM_WM_FAST_A:
        tm_class = TM_CLS_FAST;
      default: tm_class = TM_CLS_NORMAL;
    endcase
  endfunction : tm_class

  function automatic logic tm_cap_top(input logic [3:0] m);
    tm_cap_top = (m == `TM_WM_PFC_CAP) || (m == `TM_WM_PC_CAP) ||
      (m == `TM_WM_CTC_CAP) || (m == `TM_WM_FAST_CAP);
  endfunction : tm_cap_top

  function automatic logic tm_toggle_ok(input logic [3:0] m);
    tm_toggle_ok = (m == `TM_WM_PFC_A) || (m == `TM_WM_PC_A) ||
      (m == `TM_WM_FAST_CAP) || (m == `TM_WM_FAST_A);
  endfunction : tm_toggle_ok
endpackage : tm16_pkg

// File: tm16_wave_unit.sv
// Output waveform generator and pin mux for one compare channel
`timescale 1ns/1ps
module tm16_wave_unit (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Channel control and events
  input wire tm16_pkg::tm_chan_ctl_s ctl_i,
  input wire logic match_i,
  input wire logic wrap_i,
  input wire logic count_up_i,
  // Port side
  input wire logic dir_out_i,
  input wire logic port_val_i,
  output logic pin_o,
  output logic pin_oe_o
);
  import tm16_pkg::*;

  logic wave_reg;
  logic wave_next;
  logic pin_reg;
  logic oe_reg;
  logic connected;

  assign connected = (|ctl_i.action) &&
    ((ctl_i.action != `TM_ACT_TOGGLE) || ctl_i.toggle_ok);

  always_comb begin
    wave_next = wave_reg;
    unique case (ctl_i.cls)
      TM_CLS_NORMAL: begin
        if (match_i) begin
          if (ctl_i.action == `TM_ACT_TOGGLE)
            wave_next = ~wave_reg;
          else if (ctl_i.action[1])
            wave_next = ctl_i.action[0];
        end
      end
      TM_CLS_FAST: begin
        if (ctl_i.action == `TM_ACT_TOGGLE) begin
          if (match_i && ctl_i.toggle_ok)
            wave_next = ~wave_reg;
        end else if (ctl_i.action[1]) begin
          // Wrap wins so a compare at TOP leaves the BOTTOM level
          if (wrap_i)
            wave_next = ~ctl_i.action[0];
          else if (match_i)
            wave_next = ctl_i.action[0];
        end
      end
      TM_CLS_DUAL: begin
        if (match_i) begin
          if (ctl_i.action == `TM_ACT_TOGGLE) begin
            if (ctl_i.toggle_ok)
              wave_next = ~wave_reg;
          end else if (ctl_i.action[1]) begin
            wave_next = count_up_i ? ctl_i.action[0] :
              ~ctl_i.action[0];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wave_reg <= 1'b0;
    end else if (ce_i) begin
      wave_reg <= wave_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pin_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (ce_i) begin
      pin_reg <= connected ? wave_next : port_val_i;
      oe_reg <= dir_out_i;
    end
  end

  assign pin_o = pin_reg;
  assign pin_oe_o = oe_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i || !ce_i);

  pin_driver_en_a: assert property (
    !$past(reset_i) && $past(ce_i) |-> pin_oe_o == $past(dir_out_i))
    else $error("pin driver not following direction bit");
  normal_toggle_a: assert property (
    ctl_i.cls == TM_CLS_NORMAL && ctl_i.action == `TM_ACT_TOGGLE && match_i
    |=> pin_o != $past(wave_reg))
    else $error("non-PWM toggle missed");
  fast_wrap_a: assert property (
    ctl_i.cls == TM_CLS_FAST && ctl_i.action[1] && wrap_i
    |=> pin_o == !$past(ctl_i.action[0]))
    else $error("fast PWM BOTTOM level wrong");
  dual_match_a: assert property (
    ctl_i.cls == TM_CLS_DUAL && ctl_i.action[1] && match_i
    |=> pin_o == ($past(count_up_i) ~^ $past(ctl_i.action[0])) ^ 1'b1
      ^ 1'b1)
    else $error("dual-slope match level wrong");
  port_passthru_a: assert property (
    ctl_i.action == 2'b00 |=> pin_o == $past(port_val_i))
    else $error("disconnected pin not showing port value");
endmodule : tm16_wave_unit

// File: tb_tm16.sv
// Self-checking testbench for the 16-bit timer mode and output control
`timescale 1ns/1ps
`define TB_CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  mismatches++; $display("mismatch at %0t got %h exp %h", $time, g, e); \
  end end

module tb;
  import tm16_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock_i, reset_i, timer_tick_i, dir_a_i, port_a_i, port_b_i;
  logic ce_i;
  tm_bus_req_s bus;
  logic [7:0] rdata_o, v;
  logic wave_out_a_o, wave_out_a_oe_o, wave_out_b_o, wave_out_b_oe_o;
  logic capture_pin_enabled_o;
  int mismatches = 0;
  int check_count = 0;
  // Toggle code 01 in modes 5, 1 (channel A) and 14, 9 (channel B)
  logic [7:0] tab_a [4] = '{8'h41, 8'h41, 8'h12, 8'h11};
  logic [7:0] tab_b [4] = '{8'h08, 8'h00, 8'h18, 8'h10};

  tm16_timer uut (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .bus_i(bus),
    .rdata_o(rdata_o),
    .timer_tick_i(timer_tick_i),
    .capture_in_pin_i(1'b0),
    .dir_a_i(dir_a_i),
    .dir_b_i(1'b1),
    .port_a_i(port_a_i),
    .port_b_i(port_b_i),
    .wave_out_a_o(wave_out_a_o),
    .wave_out_a_oe_o(wave_out_a_oe_o),
    .wave_out_b_o(wave_out_b_o),
    .wave_out_b_oe_o(wave_out_b_oe_o),
    .capture_pin_enabled_o(capture_pin_enabled_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // ----------------------------------------
  // Bus and timing tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask : wr

  // Control A then control B with the strobe held, no gap
  task automatic wr_mode(input logic [7:0] lo, input logic [7:0] hi);
    @(posedge clock_i);
    bus.addr <= 8'h80;
    bus.wdata <= lo;
    bus.wr <= 1'b1;
    @(posedge clock_i);
    bus.addr <= 8'h81;
    bus.wdata <= hi;
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask : wr_mode

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // High byte first, low byte commits the pair
  task automatic w16(input logic [7:0] a, input logic [15:0] d);
    wr(a + 8'h01, d[15:8]);
    wr(a, d[7:0]);
  endtask : w16

  task automatic tick(input int n);
    @(posedge clock_i);
    timer_tick_i <= 1'b1;
    repeat (n) @(posedge clock_i);
    timer_tick_i <= 1'b0;
  endtask : tick

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_cyc

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge clock_i);
    mismatches++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    timer_tick_i = 1'b0;
    dir_a_i = 1'b0;
    port_a_i = 1'b0;
    port_b_i = 1'b1;
    bus = '0;
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(8'h80, v);
    `TB_CHK(v, 8'h00);
    rd(8'h81, v);
    `TB_CHK(v, 8'h00);
    rd(8'h83, v);
    `TB_CHK(v, 8'h00);
    `TB_CHK(capture_pin_enabled_o, 1'b1);
    wr(8'h80, 8'hff);
    rd(8'h80, v);
    `TB_CHK(v, 8'hf3);
    wr(8'h81, 8'h18);
    wr(8'h80, 8'h02);
    rd(8'h81, v);
    `TB_CHK(v, 8'h18);
    `TB_CHK(capture_pin_enabled_o, 1'b0);
    wr(8'h81, 8'h00);
    wr(8'h80, 8'h00);
    // Port function while disconnected
    @(posedge clock_i);
    port_a_i <= 1'b1;
    dir_a_i <= 1'b1;
    wait_cyc(2);
    `TB_CHK(wave_out_a_o, 1'b1);
    `TB_CHK(wave_out_a_oe_o, 1'b1);
    @(posedge clock_i);
    port_a_i <= 1'b0;
    dir_a_i <= 1'b0;
    wait_cyc(2);
    `TB_CHK(wave_out_a_oe_o, 1'b0);
    `TB_CHK(wave_out_a_o, 1'b0);
    @(posedge clock_i);
    dir_a_i <= 1'b1;
    // Non-PWM codes toggle, clear, set; B kept out of reach
    w16(8'h8a, 16'h0100);
    w16(8'h88, 16'h0005);
    for (int c = 1; c < 4; c++) begin
      wr(8'h80, 8'(c << 6));
      w16(8'h84, 16'h0000);
      wr(8'h90, 8'h0f);
      tick(6);
      wait_cyc(2);
      `TB_CHK(wave_out_a_o, (c != 2));
      rd(8'h90, v);
      `TB_CHK(v, 8'h02);
    end
    // Fast PWM 8-bit inverting across a wrap
    wr_mode(8'hc1, 8'h08);
    w16(8'h88, 16'h0010);
    w16(8'h84, 16'h00fe);
    wr(8'h90, 8'h0f);
    tick(3);
    wait_cyc(2);
    `TB_CHK(wave_out_a_o, 1'b0);
    rd(8'h90, v);
    `TB_CHK(v, 8'h01);
    tick(17);
    wait_cyc(2);
    `TB_CHK(wave_out_a_o, 1'b1);
    // Toggle code disconnects outside the normal class except channel A in modes 9/11/14/15
    for (int i = 0; i < 4; i++) begin
      wr_mode(tab_a[i], tab_b[i]);
      wait_cyc(2);
      `TB_CHK((i < 2 ? wave_out_a_o : wave_out_b_o), (i >= 2));
    end
    // Mode 9, TOP 16: A toggles at TOP, B inverting, B loads at BOTTOM
    @(posedge clock_i);
    port_a_i <= 1'b1;
    wr_mode(8'h71, 8'h10);
    w16(8'h8a, 16'h0004);
    w16(8'h84, 16'h0000);
    wr(8'h90, 8'h0f);
    tick(37);
    wait_cyc(2);
    `TB_CHK(wave_out_a_o, 1'b0);
    `TB_CHK(wave_out_b_o, 1'b1);
    rd(8'h90, v);
    `TB_CHK(v, 8'h07);
    // Clock enable low freezes the counter despite ticks
    @(posedge clock_i);
    ce_i <= 1'b0;
    timer_tick_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    ce_i <= 1'b1;
    timer_tick_i <= 1'b0;
    rd(8'h84, v);
    `TB_CHK(v, 8'h05);
    tally_and_finish();
  end
endmodule : tb
